// ### hw/qpot_line_filter.sv
// qpot_line_filter: two-flop synchroniser and deglitch filter for scl and sda
// assumes lines idle high and change slowly against the system clock
`timescale 1ns/1ps
`default_nettype none
module qpot_line_filter #(
   parameter int unsigned LEN = qpot_pkg::FILT_CYC
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   // raw and cleaned lines
   input wire qpot_pkg::qpot_lines_t raw_i,
   output qpot_pkg::qpot_lines_t clean_o
);
   import qpot_pkg::*;

   qpot_lines_t meta_ff;
   qpot_lines_t sync_ff;
   qpot_lines_t clean_ff;
   logic [1:0][7:0] cnt_ff;

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         meta_ff <= LINES_IDLE;
         sync_ff <= LINES_IDLE;
      end else begin
         meta_ff <= raw_i;
         sync_ff <= meta_ff;
      end
   end

   // a line must hold its new level LEN+1 cycles before it is believed
   for (genvar i = 0; i < 2; i++) begin : g_bit
      always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
         if (!arst_n_i) begin
            clean_ff[i] <= LINES_IDLE[i];
            cnt_ff[i] <= BYTE_ZERO;
         end else if (sync_ff[i] == clean_ff[i]) begin
            cnt_ff[i] <= BYTE_ZERO;
         end else if (cnt_ff[i] >= 8'(LEN)) begin
            clean_ff[i] <= sync_ff[i];
            cnt_ff[i] <= BYTE_ZERO;
         end else begin
            cnt_ff[i] <= cnt_ff[i] + 8'h01;
         end
      end
   end

   assign clean_o = clean_ff;
endmodule
`default_nettype wire

// ### hw/qpot_pkg.sv
// qpot_pkg: constants, carrier types and state codes for the quad pot slave
// assumes a single 250 MHz system clock and a two-wire bus sampled as pins
package qpot_pkg;

   // geometry
   localparam int unsigned CH_NUM = 4;
   localparam int unsigned SLOT_NUM = 4;
   localparam int unsigned POS_W = 6;
   localparam int unsigned TAP_NUM = 64;

   // clock and timing
   localparam int unsigned SYS_CLK_MHZ = 250;
   // deglitch window on the bus lines, in ns; a glitch shorter than this is dropped
   localparam int unsigned FILT_NS = 8;
   localparam int unsigned FILT_CYC = (FILT_NS * SYS_CLK_MHZ) / 1000;
   // nonvolatile write busy time in cycles; no figure given, plain default
   localparam int unsigned NVW_CYC_DEF = 1000;

   // device-type identifier in the upper address nibble; value is arbitrary
   localparam logic [3:0] DEV_TYPE_ID = 4'ha;

   // bit counting
   localparam logic [2:0] BIT_FIRST = 3'h0;
   localparam logic [2:0] BIT_LAST = 3'h7;

   // reset values
   localparam logic [POS_W-1:0] SAVED_RST = 6'h00;
   localparam logic [POS_W-1:0] WIPER_RST = 6'h00;
   localparam logic [1:0] BYTE_PAD = 2'h0;
   localparam logic [7:0] BYTE_ZERO = 8'h00;

   // opcodes in the upper command nibble
   localparam logic [3:0] OP_RD_WIPER = 4'h9;
   localparam logic [3:0] OP_WR_WIPER = 4'ha;
   localparam logic [3:0] OP_RD_SAVED = 4'hb;
   localparam logic [3:0] OP_WR_SAVED = 4'hc;
   localparam logic [3:0] OP_XFR_TO_WIPER = 4'hd;
   localparam logic [3:0] OP_XFR_TO_SAVED = 4'he;

   // sampled bus lines
   typedef struct packed {
      logic scl;
      logic sda;
   } qpot_lines_t;

   localparam qpot_lines_t LINES_IDLE = 2'h3;

   // slave address byte
   typedef struct packed {
      logic [3:0] type_id;
      logic [3:0] dev_addr;
   } qpot_addr_t;

   // command byte: opcode, slot_select_hi/lo, channel_select_hi/lo
   typedef struct packed {
      logic [3:0] op;
      logic [1:0] slot;
      logic [1:0] chan;
   } qpot_cmd_t;

   typedef enum logic [3:0] {
      ST_RECALL = 4'h0,
      ST_IDLE = 4'h1,
      ST_ADDR = 4'h2,
      ST_ADDR_ACK = 4'h3,
      ST_CMD = 4'h4,
      ST_CMD_ACK = 4'h5,
      ST_RX = 4'h6,
      ST_RX_ACK = 4'h7,
      ST_TX = 4'h8,
      ST_TX_ACK = 4'h9,
      ST_WAIT = 4'ha
   } qpot_state_t;

endpackage

// ### hw/qpot_tap_decode.sv
// qpot_tap_decode: registered one-of-n decode of a wiper position
// assumes pos_i comes from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module qpot_tap_decode #(
   parameter int unsigned POS_W = qpot_pkg::POS_W,
   parameter int unsigned TAP_NUM = qpot_pkg::TAP_NUM
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   // position in, one-hot tap enables out
   input wire logic [POS_W-1:0] pos_i,
   output logic [TAP_NUM-1:0] tap_o
);
   import qpot_pkg::*;

   logic [TAP_NUM-1:0] tap_ff;

   // exactly one switch on, including during reset (tap zero)
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tap_ff <= TAP_NUM'(1);
      end else begin
         tap_ff <= TAP_NUM'(1) << pos_i; // R21
      end
   end

   assign tap_o = tap_ff;
endmodule
`default_nettype wire

// ### hw/qpot_two_wire_slave.sv
// qpot_two_wire_slave: two-wire slave and register set of a four-channel pot
// assumes the bus master makes scl; all pins are asynchronous to sys_clk_i
`timescale 1ns/1ps
`default_nettype none

// What this block does
// R01: each channel keeps one wiper register and four saved slots, all bus accessible
// R02: the wiper register value selects which of 64 taps feeds the wiper
// R03: after power-up slot zero of each channel is copied into its wiper
// R04: write-protect low blocks every write into the saved slots
// R05: address-select pins are the low address nibble; only a match starts work
// R06: up to sixteen devices share a bus, told apart by their pins
// R07: sda is only pulled low or released, never driven high
// R08: the master starts every transfer and makes the clock; we are slave only
// R09: sda changes only while scl is low; high-scl changes are start or stop
// R10: start is sda falling while scl high and opens every command
// R11: bus activity is ignored as a command until a start has been seen
// R12: stop is sda rising while scl high and ends each transaction
// R13: the transmitter releases sda after its eighth bit
// R14: on the ninth clock the receiver pulls sda low to acknowledge
// R15: acknowledge a start followed by our own address
// R16: acknowledge the command byte after the address
// R17: acknowledge a data byte that follows the command byte
// R18: upper nibble is the device type; all four select bits must match
// R19: while a saved-slot write is busy the address is not acknowledged
// R20: command byte holds opcode, two slot bits, then two channel bits
// R21: the six-bit position enables exactly one of sixty-four tap switches
// R22: scl and sda are synchronised and deglitched before edge detection
module qpot_two_wire_slave #(
   parameter int unsigned NVW_CYC = qpot_pkg::NVW_CYC_DEF,
   parameter logic [3:0] TYPE_ID = qpot_pkg::DEV_TYPE_ID
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   // two-wire bus
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   // straps
   input wire logic [3:0] addr_select_pins_i,
   input wire logic wp_n_i,
   // wiper tap enables, one-hot per channel
   output logic [qpot_pkg::CH_NUM-1:0][qpot_pkg::TAP_NUM-1:0] tap_sel_o,
   // status
   output logic nv_busy_o
);
   import qpot_pkg::*;

   // pin synchronisers for straps
   logic [3:0] addr_meta_ff;
   logic [3:0] addr_sync_ff;
   logic wp_meta_ff;
   logic wp_sync_ff;

   // cleaned lines and their previous values
   qpot_lines_t raw_lines;
   qpot_lines_t lines;
   qpot_lines_t lines_q_ff;

   // bus events
   logic scl_rise;
   logic scl_fall;
   logic start_evt;
   logic stop_evt;

   // protocol state
   qpot_state_t st_ff;
   logic [2:0] bit_cnt_ff;
   logic [7:0] shift_ff;
   logic [7:0] tx_ff;
   logic ack_on_ff;
   logic oe_ff;
   qpot_cmd_t cmd_ff;
   logic [7:0] byte_in;
   qpot_addr_t addr_in;

   // commit strobes
   logic do_cmd;
   logic do_data;
   logic wp_ok;

   // register set
   logic [POS_W-1:0] wiper_position_reg [CH_NUM];
   logic [POS_W-1:0] saved_position_regs [CH_NUM][SLOT_NUM];
   logic nv_pend_ff;
   logic [31:0] busy_cnt_ff;
   logic nv_busy_ff;

   // widen a position to a bus byte
   function automatic logic [7:0] pos_byte(input logic [POS_W-1:0] pos);
      pos_byte = {BYTE_PAD, pos};
   endfunction

   // first bit on the wire of a byte sent msb first
   function automatic logic byte_msb(input logic [7:0] b);
      byte_msb = b[7];
   endfunction

   // opcodes that send a data byte back to the master
   function automatic logic is_read(input logic [3:0] op);
      is_read = (op == OP_RD_WIPER) || (op == OP_RD_SAVED);
   endfunction

   // opcodes that take a data byte from the master
   function automatic logic is_write(input logic [3:0] op);
      is_write = (op == OP_WR_WIPER) || (op == OP_WR_SAVED);
   endfunction

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         addr_meta_ff <= 4'h0;
         addr_sync_ff <= 4'h0;
         wp_meta_ff <= 1'b0;
         wp_sync_ff <= 1'b0;
      end else begin
         addr_meta_ff <= addr_select_pins_i;
         addr_sync_ff <= addr_meta_ff;
         wp_meta_ff <= wp_n_i;
         wp_sync_ff <= wp_meta_ff;
      end
   end

   assign raw_lines.scl = scl_i;
   assign raw_lines.sda = sda_i;

   qpot_line_filter #(
      .LEN(FILT_CYC)
   ) u_filter (
      .sys_clk_i(sys_clk_i),
      .arst_n_i(arst_n_i),
      .raw_i(raw_lines),
      .clean_o(lines) // R22
   );

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         lines_q_ff <= LINES_IDLE;
      end else begin
         lines_q_ff <= lines;
      end
   end

   // edges found on the cleaned lines only
   assign scl_rise = lines.scl && !lines_q_ff.scl;
   assign scl_fall = !lines.scl && lines_q_ff.scl;
   // sda moving while scl stays high is never data
   assign start_evt = lines.scl && lines_q_ff.scl && lines_q_ff.sda && !lines.sda; // R09 R10
   assign stop_evt = lines.scl && lines_q_ff.scl && !lines_q_ff.sda && lines.sda; // R09 R12

   assign byte_in = {shift_ff[6:0], lines.sda};
   assign addr_in = byte_in;
   assign wp_ok = wp_sync_ff;
   assign do_cmd = (st_ff == ST_CMD_ACK) && scl_fall && ack_on_ff;
   assign do_data = (st_ff == ST_RX_ACK) && scl_fall && ack_on_ff;

   // protocol sequencer; we only ever follow the master's clock
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin // R08
      if (!arst_n_i) begin
         st_ff <= ST_RECALL;
         bit_cnt_ff <= BIT_FIRST;
         ack_on_ff <= 1'b0;
      end else if (st_ff == ST_RECALL) begin
         st_ff <= ST_IDLE;
      end else if (stop_evt) begin
         st_ff <= ST_IDLE; // R12
         ack_on_ff <= 1'b0;
      end else if (start_evt) begin
         // a repeated start restarts the address phase
         st_ff <= ST_ADDR; // R10 R11
         bit_cnt_ff <= BIT_FIRST;
         ack_on_ff <= 1'b0;
      end else begin
         case (st_ff)
            ST_ADDR: begin
               if (scl_rise) begin
                  bit_cnt_ff <= bit_cnt_ff + 3'h1;
                  if (bit_cnt_ff == BIT_LAST) begin
                     // wrong type, wrong pins or busy: stay silent till next start
                     if ((addr_in.type_id == TYPE_ID) // R18
                         && (addr_in.dev_addr == addr_sync_ff) // R05 R06
                         && !nv_busy_ff) begin // R19
                        st_ff <= ST_ADDR_ACK; // R15
                     end else begin
                        st_ff <= ST_WAIT;
                     end
                  end
               end
            end
            ST_ADDR_ACK: begin
               if (scl_fall) begin
                  ack_on_ff <= !ack_on_ff;
                  if (ack_on_ff) begin
                     st_ff <= ST_CMD;
                  end
               end
            end
            ST_CMD: begin
               if (scl_rise) begin
                  bit_cnt_ff <= bit_cnt_ff + 3'h1;
                  if (bit_cnt_ff == BIT_LAST) begin
                     st_ff <= ST_CMD_ACK; // R16
                  end
               end
            end
            ST_CMD_ACK: begin
               if (scl_fall) begin
                  ack_on_ff <= !ack_on_ff;
                  if (ack_on_ff) begin
                     if (is_read(cmd_ff.op)) begin
                        st_ff <= ST_TX;
                     end else if (is_write(cmd_ff.op)) begin
                        st_ff <= ST_RX;
                     end else begin
                        st_ff <= ST_WAIT;
                     end
                  end
               end
            end
            ST_RX: begin
               if (scl_rise) begin
                  bit_cnt_ff <= bit_cnt_ff + 3'h1;
                  if (bit_cnt_ff == BIT_LAST) begin
                     st_ff <= ST_RX_ACK; // R17
                  end
               end
            end
            ST_RX_ACK: begin
               if (scl_fall) begin
                  ack_on_ff <= !ack_on_ff;
                  if (ack_on_ff) begin
                     st_ff <= ST_WAIT;
                  end
               end
            end
            ST_TX: begin
               if (scl_rise) begin
                  bit_cnt_ff <= bit_cnt_ff + 3'h1;
                  if (bit_cnt_ff == BIT_LAST) begin
                     st_ff <= ST_TX_ACK;
                  end
               end
            end
            ST_TX_ACK: begin
               // master answer on the ninth clock is not needed: one byte only
               if (scl_rise) begin
                  st_ff <= ST_WAIT;
               end
            end
            ST_IDLE, ST_WAIT: begin
               st_ff <= st_ff; // R11
            end
            default: begin
               st_ff <= ST_IDLE;
            end
         endcase
      end
   end

   // receive shifter, msb first; the ninth clock must not push the ack bit in
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         shift_ff <= BYTE_ZERO;
      end else if (scl_rise && ((st_ff == ST_ADDR) || (st_ff == ST_CMD) || (st_ff == ST_RX))) begin
         shift_ff <= byte_in;
      end
   end

   // command latch
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cmd_ff <= BYTE_ZERO;
      end else if ((st_ff == ST_CMD) && scl_rise && (bit_cnt_ff == BIT_LAST)) begin
         cmd_ff <= byte_in; // R20
      end
   end

   // sda driver: pull low or release, changed on scl fall, released at start or stop
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         oe_ff <= 1'b0;
         tx_ff <= BYTE_ZERO;
      end else if (stop_evt || start_evt) begin
         oe_ff <= 1'b0;
      end else if (scl_fall) begin // R09
         case (st_ff)
            ST_ADDR_ACK, ST_CMD_ACK, ST_RX_ACK: begin
               oe_ff <= !ack_on_ff; // R14 R07
               if (do_cmd && is_read(cmd_ff.op)) begin
                  if (cmd_ff.op == OP_RD_WIPER) begin
                     tx_ff <= pos_byte(wiper_position_reg[cmd_ff.chan]) << 1;
                     oe_ff <= !byte_msb(pos_byte(wiper_position_reg[cmd_ff.chan]));
                  end else begin
                     tx_ff <= pos_byte(saved_position_regs[cmd_ff.chan][cmd_ff.slot]) << 1;
                     oe_ff <= !byte_msb(pos_byte(saved_position_regs[cmd_ff.chan][cmd_ff.slot]));
                  end
               end
            end
            ST_TX: begin
               oe_ff <= !tx_ff[7]; // R07
               tx_ff <= tx_ff << 1;
            end
            default: begin
               // release after eighth transmitted bit and everywhere else
               oe_ff <= 1'b0; // R13
            end
         endcase
      end
   end

   // wiper registers: recall, transfer in, direct write
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         for (int c = 0; c < CH_NUM; c++) begin
            wiper_position_reg[c] <= WIPER_RST;
         end
      end else if (st_ff == ST_RECALL) begin
         for (int c = 0; c < CH_NUM; c++) begin
            wiper_position_reg[c] <= saved_position_regs[c][0]; // R03
         end
      end else if (do_cmd && (cmd_ff.op == OP_XFR_TO_WIPER)) begin
         wiper_position_reg[cmd_ff.chan] <= saved_position_regs[cmd_ff.chan][cmd_ff.slot]; // R01
      end else if (do_data && (cmd_ff.op == OP_WR_WIPER)) begin
         wiper_position_reg[cmd_ff.chan] <= shift_ff[POS_W-1:0]; // R01
      end
   end

   // saved slots: arst_n_i stands for power-on, so they restart at a constant
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         for (int c = 0; c < CH_NUM; c++) begin
            for (int s = 0; s < SLOT_NUM; s++) begin
               saved_position_regs[c][s] <= SAVED_RST;
            end
         end
      end else if (wp_ok) begin // R04
         if (do_cmd && (cmd_ff.op == OP_XFR_TO_SAVED)) begin
            saved_position_regs[cmd_ff.chan][cmd_ff.slot] <= wiper_position_reg[cmd_ff.chan];
         end else if (do_data && (cmd_ff.op == OP_WR_SAVED)) begin
            saved_position_regs[cmd_ff.chan][cmd_ff.slot] <= shift_ff[POS_W-1:0]; // R01
         end
      end
   end

   // busy time starts at the stop that closes an accepted saved-slot write
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         nv_pend_ff <= 1'b0;
         busy_cnt_ff <= 32'h0;
         nv_busy_ff <= 1'b0;
      end else begin
         if (wp_ok && ((do_cmd && (cmd_ff.op == OP_XFR_TO_SAVED))
                       || (do_data && (cmd_ff.op == OP_WR_SAVED)))) begin
            nv_pend_ff <= 1'b1;
         end else if (stop_evt) begin
            nv_pend_ff <= 1'b0;
         end
         if (stop_evt && nv_pend_ff) begin
            busy_cnt_ff <= 32'(NVW_CYC); // R19
         end else if (busy_cnt_ff != 32'h0) begin
            busy_cnt_ff <= busy_cnt_ff - 32'h1;
         end
         nv_busy_ff <= (stop_evt && nv_pend_ff) || (busy_cnt_ff > 32'h1);
      end
   end

   // tap decoders, one per channel
   for (genvar c = 0; c < CH_NUM; c++) begin : g_tap
      qpot_tap_decode #(
         .POS_W(POS_W),
         .TAP_NUM(TAP_NUM)
      ) u_tap (
         .sys_clk_i(sys_clk_i),
         .arst_n_i(arst_n_i),
         .pos_i(wiper_position_reg[c]),
         .tap_o(tap_sel_o[c]) // R02
      );
   end

   // open drain: data value is always low, only the enable moves
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         sda_o <= 1'b0;
      end else begin
         sda_o <= 1'b0; // R07
      end
   end

   assign sda_oe_o = oe_ff;
   assign nv_busy_o = nv_busy_ff;

endmodule
`default_nettype wire

// ### tb/qpot_master.sv
// qpot_master: behavioural two-wire bus master, scl period about 125 ns
// assumes sda is pulled up outside; moves only after falling clock edges
`timescale 1ns/1ps
`default_nettype none
module qpot_master (
   // clock
   input wire logic clk_i,
   // bus
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_low_o
);
   initial begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end
   task automatic w(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   // sda moves only mid low phase, so no start or stop is faked
   task automatic clk_bit(input logic b, output logic r);
      w(8);
      sda_low_o = !b;
      w(8);
      scl_o = 1'b1;
      w(8);
      r = sda_i;
      w(7);
      scl_o = 1'b0;
   endtask
   task automatic start();
      w(8);
      sda_low_o = 1'b0;
      w(8);
      scl_o = 1'b1;
      w(16);
      sda_low_o = 1'b1;
      w(16);
      scl_o = 1'b0;
   endtask
   task automatic stop();
      w(8);
      sda_low_o = 1'b1;
      w(8);
      scl_o = 1'b1;
      w(16);
      sda_low_o = 1'b0;
      w(16);
   endtask
   task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         clk_bit(d[i], q[i]);
      end
      clk_bit(1'b1, ack);
   endtask
endmodule
`default_nettype wire

// ### tb/qpot_sva.sv
// qpot_sva: port-level checks of the quad pot two-wire slave
// assumes sda_i is the resolved, pulled-up bus wire
`timescale 1ns/1ps
`default_nettype none
module qpot_sva #(
   parameter int unsigned NVW_CYC = 50
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   // bus and straps
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   input wire logic [3:0] addr_select_pins_i,
   input wire logic wp_n_i,
   // outputs
   input wire logic [qpot_pkg::CH_NUM-1:0][qpot_pkg::TAP_NUM-1:0] tap_sel_o,
   input wire logic nv_busy_o
);
   import qpot_pkg::*;
   logic scl_q_ff;
   logic sda_q_ff;
   logic frame_ff;
   int unsigned busy_cnt_ff;
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!arst_n_i);
   // raw lines, unfiltered: the frame flag is deliberately stricter than the design
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         scl_q_ff <= 1'b1;
         sda_q_ff <= 1'b1;
      end else begin
         scl_q_ff <= scl_i;
         sda_q_ff <= sda_i;
      end
   end
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         frame_ff <= 1'b0;
      end else if (scl_q_ff && scl_i && sda_q_ff && !sda_i) begin
         frame_ff <= 1'b1;
      end else if (scl_q_ff && scl_i && !sda_q_ff && sda_i) begin
         frame_ff <= 1'b0;
      end
   end
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         busy_cnt_ff <= 32'h0;
      end else begin
         busy_cnt_ff <= nv_busy_o ? busy_cnt_ff + 32'h1 : 32'h0;
      end
   end
   property p_drain; sda_o == 1'b0; endproperty
   a_drain: assert property (p_drain) else $error("sda data not low");
   property p_hot; $onehot(tap_sel_o[0]) && $onehot(tap_sel_o[1])
      && $onehot(tap_sel_o[2]) && $onehot(tap_sel_o[3]); endproperty
   a_hot: assert property (p_hot) else $error("tap enables not one-hot");
   property p_low; $changed(sda_oe_o) |-> !scl_i; endproperty
   a_low: assert property (p_low) else $error("sda moved with scl high");
   property p_hold; $rose(scl_i) |=> $stable(sda_oe_o)[*8]; endproperty
   a_hold: assert property (p_hold) else $error("sda moved in high phase");
   property p_frame; $rose(sda_oe_o) |-> frame_ff; endproperty
   a_frame: assert property (p_frame) else $error("drive outside a frame");
   property p_busy; nv_busy_o |-> !sda_oe_o; endproperty
   a_busy: assert property (p_busy) else $error("answered while busy");
   property p_blen; $fell(nv_busy_o) |-> busy_cnt_ff == NVW_CYC; endproperty
   a_blen: assert property (p_blen) else $error("busy time wrong");
   property p_wp; $rose(nv_busy_o) |-> wp_n_i && $past(wp_n_i, 4); endproperty
   a_wp: assert property (p_wp) else $error("write while protected");
   c_busy: cover property ($rose(nv_busy_o));
   c_ack: cover property ($rose(sda_oe_o));
   c_tap: cover property (tap_sel_o[1][42]);
endmodule
bind qpot_two_wire_slave qpot_sva #(.NVW_CYC(NVW_CYC)) i_sva (
   .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .scl_i(scl_i), .sda_i(sda_i),
   .sda_o(sda_o), .sda_oe_o(sda_oe_o), .addr_select_pins_i(addr_select_pins_i),
   .wp_n_i(wp_n_i), .tap_sel_o(tap_sel_o), .nv_busy_o(nv_busy_o));
`default_nettype wire

// ### tb/testbench.sv
// testbench: quad pot slave driven by the bus master model
// assumes qpot_pkg constants; sda is an open-drain wire with pull-up
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import qpot_pkg::*;
   // long enough that a poll frame lands inside the busy time
   localparam int unsigned NVW = 600;
   logic sys_clk_i = 1'b0;
   logic arst_n_i;
   logic [3:0] pins;
   logic wp_n;
   logic scl;
   logic mst_low;
   wire logic sda;
   logic sda_o;
   logic sda_oe_o;
   logic nv_busy_o;
   logic [CH_NUM-1:0][TAP_NUM-1:0] tap_sel;
   logic [7:0] ad;
   int failures = 0;
   int tests_run = 0;
   assign sda = !(mst_low || sda_oe_o);
   always #2 sys_clk_i = ~sys_clk_i;
   qpot_two_wire_slave #(.NVW_CYC(NVW), .TYPE_ID(DEV_TYPE_ID)) i_dut (
      .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .scl_i(scl), .sda_i(sda),
      .sda_o(sda_o), .sda_oe_o(sda_oe_o), .addr_select_pins_i(pins), .wp_n_i(wp_n),
      .tap_sel_o(tap_sel), .nv_busy_o(nv_busy_o));
   qpot_master i_mst (.clk_i(sys_clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(mst_low));
   task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // one frame of nb bytes; ak bits are low for an acknowledge
   task automatic txn(input logic [7:0] c, input logic [7:0] d, input int nb,
                      output logic [7:0] q, output logic [2:0] ak);
      logic [7:0] junk;
      ak = 3'h7;
      q = 8'h00;
      i_mst.start();
      i_mst.xfer(ad, junk, ak[2]);
      if (nb > 1) i_mst.xfer(c, junk, ak[1]);
      if (nb > 2) i_mst.xfer(d, q, ak[0]);
      i_mst.stop();
   endtask
   task automatic poll();
      logic [7:0] q;
      logic [2:0] ak;
      txn(8'h00, 8'h00, 1, q, ak);
      chk("ack while busy", ak[2], 1'b1);
      for (int n = 0; n < 8 && ak[2] === 1'b1; n++) txn(8'h00, 8'h00, 1, q, ak);
      chk("ack after busy", ak[2], 1'b0);
   endtask
   task automatic settle();
      repeat (20) @(negedge sys_clk_i);
   endtask
   initial begin
      repeat (60000) @(posedge sys_clk_i);
      failures++;
      summarize();
   end
   initial begin
      logic [7:0] q;
      logic [2:0] ak;
      logic [7:0] good;
      arst_n_i = 1'b0;
      pins = 4'h3;
      wp_n = 1'b1;
      settle();
      arst_n_i = 1'b1;
      settle();
      good = {DEV_TYPE_ID, pins};
      for (int k = 0; k < 4; k++) chk("tap after reset", tap_sel[k], 64'h1);
      for (int k = 0; k < 8; k++) begin
         ad = good ^ (8'h01 << k);
         txn({OP_WR_WIPER, 4'h1}, 8'h2a, 3, q, ak);
         chk("bad address", ak, 3'h7);
      end
      chk("tap untouched", tap_sel[1], 64'h1);
      ad = good;
      txn({OP_WR_WIPER, 4'h1}, 8'h2a, 3, q, ak);
      chk("write wiper acks", ak, 3'h0);
      settle();
      chk("tap ch1", tap_sel[1], 64'h1 << 42);
      txn({OP_RD_WIPER, 4'h1}, 8'hff, 3, q, ak);
      chk("read wiper", q, 8'h2a);
      txn({OP_WR_SAVED, 2'h2, 2'h0}, 8'h15, 3, q, ak);
      chk("busy after stop", nv_busy_o, 1'b1);
      poll();
      txn({OP_RD_SAVED, 2'h2, 2'h0}, 8'hff, 3, q, ak);
      chk("read slot", q, 8'h15);
      txn({OP_XFR_TO_WIPER, 2'h2, 2'h0}, 8'h00, 2, q, ak);
      chk("xfer acks", ak[2:1], 2'h0);
      settle();
      chk("tap ch0", tap_sel[0], 64'h1 << 21);
      txn({OP_XFR_TO_SAVED, 2'h3, 2'h1}, 8'h00, 2, q, ak);
      poll();
      txn({OP_RD_SAVED, 2'h3, 2'h1}, 8'hff, 3, q, ak);
      chk("slot from wiper", q, 8'h2a);
      wp_n = 1'b0;
      settle();
      txn({OP_WR_SAVED, 2'h2, 2'h0}, 8'h3f, 3, q, ak);
      chk("protected busy", nv_busy_o, 1'b0);
      txn({OP_RD_SAVED, 2'h2, 2'h0}, 8'hff, 3, q, ak);
      chk("protected slot", q, 8'h15);
      wp_n = 1'b1;
      pins = 4'hc;
      settle();
      ad = {DEV_TYPE_ID, 4'hc};
      txn(8'h00, 8'h00, 1, q, ak);
      chk("new pins ack", ak[2], 1'b0);
      arst_n_i = 1'b0;
      settle();
      arst_n_i = 1'b1;
      settle();
      chk("recall ch1", tap_sel[1], 64'h1);
      summarize();
   end
endmodule
`default_nettype wire
